// File: rtl/rcs_pkg.sv
// Behaviour
// - Combined measure, dry-contact limit and address-set legacy commands get NAK, no action.
// - Range save, display test and keypad lock legacy commands get ACK, otherwise ignored.
// - Legacy load type: complex selects mode three, real selects mode one, never two.
// - Start, stop and fetch-latest-result legacy commands are executed.
// - Auto range on/off and explicit range setting are executed.
// - Questionable event and condition readable; questionable enable writable and readable.
// - Operation event and condition readable; operation enable writable and readable.
// - Status preset returns operation and questionable enables to preset values.
// - Standard event register readable, its enable read/write; clear-status clears events.
// - Continuous mode: output buffer always overwritten by newest measurement value.
// - Continuous mode: operation bit 8 set while a valid value is present.
// - Continuous mode: questionable bit 9 set while any error is present.
// - Any attempt to set group or user station address is refused with NAK.
// - Legacy-only commands recognised only while compatibility mode is selected.
`default_nettype none
package rcs_pkg;
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam int CTRL_COMPAT_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Interrupt events
  localparam int IRQ_W = 3;
  localparam int IRQ_NAK_BIT = 0;
  localparam int IRQ_MEAS_BIT = 1;
  localparam int IRQ_ERR_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // SCPI status registers
  localparam int STAT_W = 16;
  localparam int OPER_MEAS_BIT = 8;
  localparam int QUES_ERR_BIT = 9;
  localparam logic [15:0] ENABLE_PRESET = 16'h0000;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam int ESR_W = 8;
  localparam int ESR_CMD_ERR_BIT = 5;
  localparam logic [7:0] ESR_RESET = 8'h00;
  // Measurement setup
  localparam int RANGE_W = 4;
  localparam logic [3:0] RANGE_RESET = 4'h0;
  localparam int VALUE_W = 24;
  localparam logic [1:0] LOAD_MODE_ONE = 2'h1;
  localparam logic [1:0] LOAD_MODE_TWO = 2'h2;
  localparam logic [1:0] LOAD_MODE_THREE = 2'h3;
  localparam int STATE_RANGE_LSB = 3;
  localparam int STATE_LOAD_LSB = 7;

  typedef enum logic [4:0] {
    CMD_MEAS_COMBINED = 5'h00,
    CMD_READ_COMBINED = 5'h01,
    CMD_FETCH = 5'h02,
    CMD_START = 5'h03,
    CMD_STOP = 5'h04,
    CMD_RANGE_AUTO = 5'h05,
    CMD_RANGE_SET = 5'h06,
    CMD_RANGE_SAVE = 5'h07,
    CMD_LOAD_TYPE = 5'h08,
    CMD_DRY_LIMIT = 5'h09,
    CMD_ADDR_GROUP = 5'h0A,
    CMD_ADDR_USER = 5'h0B,
    CMD_DISPLAY_TEST = 5'h0C,
    CMD_KEYPAD_LOCK = 5'h0D,
    CMD_QUES_EVENT_Q = 5'h0E,
    CMD_QUES_COND_Q = 5'h0F,
    CMD_QUES_ENABLE = 5'h10,
    CMD_QUES_ENABLE_Q = 5'h11,
    CMD_OPER_EVENT_Q = 5'h12,
    CMD_OPER_COND_Q = 5'h13,
    CMD_OPER_ENABLE = 5'h14,
    CMD_OPER_ENABLE_Q = 5'h15,
    CMD_STAT_PRESET = 5'h16,
    CMD_CLEAR_STATUS = 5'h17,
    CMD_ESR_Q = 5'h18,
    CMD_ESE = 5'h19,
    CMD_ESE_Q = 5'h1A
  } rcs_cmd_code_type;

  // Decoded command from the serial front end
  typedef struct packed {
    logic valid;
    rcs_cmd_code_type code;
    logic [15:0] arg;
  } rcs_cmd_type;

  // Answer to a command: ack or nak, optional data
  typedef struct packed {
    logic valid;
    logic ack;
    logic has_data;
    logic [23:0] data;
  } rcs_resp_type;

  // Result from the measuring engine
  typedef struct packed {
    logic valid;
    logic error;
    logic [23:0] value;
  } rcs_meas_type;
endpackage
`default_nettype wire

// File: rtl/rcs_cmd_handler.sv
`default_nettype none
module rcs_cmd_handler (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // Register port
  input wire logic [rcs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rcs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rcs_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  // Command and answer
  input wire rcs_pkg::rcs_cmd_type cmd,
  output rcs_pkg::rcs_resp_type resp,
  // Measuring engine
  input wire rcs_pkg::rcs_meas_type meas,
  output logic meas_run,
  output logic auto_range,
  output logic [rcs_pkg::RANGE_W-1:0] range_sel,
  output logic [1:0] load_mode
);
  import rcs_pkg::*;

  // Reset release through two flops
  // Assert at once, release only after two clean edges
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Register port state
  logic [1:0] ctrl_q, ctrl_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  // Engine settings
  logic run_q, run_d;
  logic auto_q, auto_d;
  logic [RANGE_W-1:0] range_q, range_d;
  logic [1:0] load_q, load_d;
  // Latest result and its error flag
  logic [VALUE_W-1:0] buf_q, buf_d;
  logic buf_valid_q, buf_valid_d;
  logic err_q, err_d;
  // SCPI status; previous conditions feed the edge detectors
  logic [STAT_W-1:0] oper_cond_prev_q, oper_cond_prev_d;
  logic [STAT_W-1:0] ques_cond_prev_q, ques_cond_prev_d;
  logic [STAT_W-1:0] oper_event_q, oper_event_d;
  logic [STAT_W-1:0] ques_event_q, ques_event_d;
  logic [STAT_W-1:0] oper_enable_q, oper_enable_d;
  logic [STAT_W-1:0] ques_enable_q, ques_enable_d;
  // Standard event status and its enable
  logic [ESR_W-1:0] esr_q, esr_d;
  logic [ESR_W-1:0] ese_q, ese_d;
  // Answer, registered so it stands exactly one cycle
  rcs_resp_type resp_q, resp_d;

  // Decoded views of registers
  logic continuous;
  logic compat;
  logic legacy_only;
  logic [STAT_W-1:0] oper_cond;
  logic [STAT_W-1:0] ques_cond;
  logic [IRQ_W-1:0] irq_set;

  assign continuous = ctrl_q[CTRL_CONT_BIT];
  assign compat = ctrl_q[CTRL_COMPAT_BIT];

  // Condition registers follow live state only in continuous mode
  always_comb begin
    oper_cond = STAT_RESET;
    ques_cond = STAT_RESET;
    oper_cond[OPER_MEAS_BIT] = continuous & buf_valid_q;
    ques_cond[QUES_ERR_BIT] = continuous & err_q;
  end

  // Commands that exist only for the predecessor instrument
  // Load type is legacy only; start and stop stay standard
  always_comb begin
    unique case (cmd.code)
      CMD_MEAS_COMBINED, CMD_READ_COMBINED, CMD_RANGE_SAVE, CMD_LOAD_TYPE,
      CMD_DRY_LIMIT, CMD_DISPLAY_TEST, CMD_KEYPAD_LOCK: legacy_only = 1'b1;
      default: legacy_only = 1'b0;
    endcase
  end

  // Next state of the whole handler
  always_comb begin
    // Defaults: registers hold, answer and read data idle
    ctrl_d = ctrl_q;
    irq_mask_d = irq_mask_q;
    rdata_d = '0;
    run_d = run_q;
    auto_d = auto_q;
    range_d = range_q;
    load_d = load_q;
    buf_d = buf_q;
    buf_valid_d = buf_valid_q;
    err_d = err_q;
    oper_event_d = oper_event_q;
    ques_event_d = ques_event_q;
    oper_enable_d = oper_enable_q;
    ques_enable_d = ques_enable_q;
    esr_d = esr_q;
    ese_d = ese_q;
    resp_d = '0;
    irq_set = '0;
    // Edge detectors track the live conditions every cycle
    oper_cond_prev_d = oper_cond;
    ques_cond_prev_d = ques_cond;

    // Command decode; one answer per command, one cycle later
    if (cmd.valid) begin
      resp_d.valid = 1'b1;
      resp_d.ack = 1'b1;
      // Legacy words outside compatibility mode are refused before decode
      if (legacy_only && !compat) begin
        resp_d.ack = 1'b0;
      end else begin
        unique case (cmd.code)
          // Refused without changing any engine setting
          CMD_MEAS_COMBINED, CMD_READ_COMBINED, CMD_DRY_LIMIT: resp_d.ack = 1'b0;
          CMD_ADDR_GROUP, CMD_ADDR_USER: resp_d.ack = 1'b0;
          // Accepted and dropped
          CMD_RANGE_SAVE, CMD_DISPLAY_TEST, CMD_KEYPAD_LOCK: resp_d.ack = 1'b1;
          CMD_LOAD_TYPE: begin
            load_d = cmd.arg[0] ? LOAD_MODE_THREE : LOAD_MODE_ONE;
          end
          CMD_START: run_d = 1'b1;
          CMD_STOP: run_d = 1'b0;
          CMD_FETCH: begin
            // Empty buffer answers nak so a stale value is never returned twice
            if (buf_valid_q) begin
              resp_d.has_data = 1'b1;
              resp_d.data = buf_q;
              buf_valid_d = 1'b0;
            end else begin
              resp_d.ack = 1'b0;
            end
          end
          CMD_RANGE_AUTO: auto_d = cmd.arg[0];
          CMD_RANGE_SET: begin
            range_d = cmd.arg[RANGE_W-1:0];
            auto_d = 1'b0;
          end
          CMD_QUES_EVENT_Q: begin
            resp_d.has_data = 1'b1;
            resp_d.data = {8'h00, ques_event_q};
            ques_event_d = STAT_RESET;
          end
          CMD_QUES_COND_Q: begin
            resp_d.has_data = 1'b1;
            resp_d.data = {8'h00, ques_cond};
          end
          CMD_QUES_ENABLE: ques_enable_d = cmd.arg;
          CMD_QUES_ENABLE_Q: begin
            resp_d.has_data = 1'b1;
            resp_d.data = {8'h00, ques_enable_q};
          end
          CMD_OPER_EVENT_Q: begin
            resp_d.has_data = 1'b1;
            resp_d.data = {8'h00, oper_event_q};
            oper_event_d = STAT_RESET;
          end
          CMD_OPER_COND_Q: begin
            resp_d.has_data = 1'b1;
            resp_d.data = {8'h00, oper_cond};
          end
          CMD_OPER_ENABLE: oper_enable_d = cmd.arg;
          CMD_OPER_ENABLE_Q: begin
            resp_d.has_data = 1'b1;
            resp_d.data = {8'h00, oper_enable_q};
          end
          CMD_STAT_PRESET: begin
            oper_enable_d = ENABLE_PRESET;
            ques_enable_d = ENABLE_PRESET;
          end
          CMD_CLEAR_STATUS: begin
            oper_event_d = STAT_RESET;
            ques_event_d = STAT_RESET;
            esr_d = ESR_RESET;
          end
          CMD_ESR_Q: begin
            resp_d.has_data = 1'b1;
            resp_d.data = {16'h0000, esr_q};
            esr_d = ESR_RESET;
          end
          CMD_ESE: ese_d = cmd.arg[ESR_W-1:0];
          CMD_ESE_Q: begin
            resp_d.has_data = 1'b1;
            resp_d.data = {16'h0000, ese_q};
          end
          default: resp_d.ack = 1'b0;
        endcase
      end
      // Every refusal is logged for software and raises the nak event
      if (!resp_d.ack) begin
        esr_d[ESR_CMD_ERR_BIT] = 1'b1;
        irq_set[IRQ_NAK_BIT] = 1'b1;
      end
    end

    // Newest value always replaces the buffer, set wins over a fetch
    // An error result leaves the buffer empty so a fetch is refused
    if (meas.valid) begin
      buf_d = meas.value;
      buf_valid_d = !meas.error;
      err_d = meas.error;
      irq_set[IRQ_MEAS_BIT] = !meas.error;
      irq_set[IRQ_ERR_BIT] = meas.error;
    end

    // Positive transitions latch into events after any read-clear
    oper_event_d = oper_event_d | (oper_cond & ~oper_cond_prev_q);
    ques_event_d = ques_event_d | (ques_cond & ~ques_cond_prev_q);

    // Register port
    // Only the low bits of a write are kept; unmapped offsets read zero
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: ctrl_d = reg_wdata[1:0];
        OFS_IRQ_MASK: irq_mask_d = reg_wdata[IRQ_W-1:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL: rdata_d = {30'h0, ctrl_q};
        OFS_STATE: rdata_d = {23'h0, load_q, range_q, auto_q, run_q, buf_valid_q};
        OFS_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
        OFS_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
        default: rdata_d = '0;
      endcase
    end

    // Write one to clear; a new event in the same cycle stays set
    irq_stat_d = irq_stat_q;
    if (reg_wr && reg_addr == OFS_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~reg_wdata[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_set;
  end

  // All state but the reset synchroniser frozen while the clock enable is low
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ctrl_q <= CTRL_RESET;
      irq_stat_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
      rdata_q <= '0;
      run_q <= 1'b0;
      auto_q <= 1'b1;
      range_q <= RANGE_RESET;
      load_q <= LOAD_MODE_ONE;
      buf_q <= '0;
      buf_valid_q <= 1'b0;
      err_q <= 1'b0;
      oper_cond_prev_q <= STAT_RESET;
      ques_cond_prev_q <= STAT_RESET;
      oper_event_q <= STAT_RESET;
      ques_event_q <= STAT_RESET;
      oper_enable_q <= ENABLE_PRESET;
      ques_enable_q <= ENABLE_PRESET;
      esr_q <= ESR_RESET;
      ese_q <= ESR_RESET;
      resp_q <= '0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
      run_q <= run_d;
      auto_q <= auto_d;
      range_q <= range_d;
      load_q <= load_d;
      buf_q <= buf_d;
      buf_valid_q <= buf_valid_d;
      err_q <= err_d;
      oper_cond_prev_q <= oper_cond_prev_d;
      ques_cond_prev_q <= ques_cond_prev_d;
      oper_event_q <= oper_event_d;
      ques_event_q <= ques_event_d;
      oper_enable_q <= oper_enable_d;
      ques_enable_q <= ques_enable_d;
      esr_q <= esr_d;
      ese_q <= ese_d;
      resp_q <= resp_d;
    end
  end

  // Outputs
  // Interrupt is a level from registers, so no pulse can be missed
  assign reg_rdata = rdata_q;
  assign irq = |(irq_stat_q & irq_mask_q);
  assign resp = resp_q;
  assign meas_run = run_q;
  assign auto_range = auto_q;
  assign range_sel = range_q;
  assign load_mode = load_q;
endmodule
`default_nettype wire

// File: verif/rcs_cmd_handler_asserts.sv
`default_nettype none
module rcs_cmd_handler_asserts (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // Command and answer
  input wire rcs_pkg::rcs_cmd_type cmd,
  input wire rcs_pkg::rcs_resp_type resp,
  // Engine controls
  input wire logic meas_run,
  input wire logic auto_range,
  input wire logic [rcs_pkg::RANGE_W-1:0] range_sel,
  input wire logic [1:0] load_mode
);
  import rcs_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Command taken on this edge
  wire logic take = cmd.valid && ce;
  // Load type accepted with a given choice
  sequence s_load(bit cplx);
    take && cmd.code == CMD_LOAD_TYPE && cmd.arg[0] == cplx ##1 resp.ack;
  endsequence
  a_resp_follows: assert property (take |=> resp.valid) else $error("no answer");
  a_refused_nak: assert property (take && cmd.code inside {CMD_MEAS_COMBINED,
    CMD_READ_COMBINED, CMD_DRY_LIMIT, CMD_ADDR_GROUP, CMD_ADDR_USER} |=> !resp.ack)
    else $error("refused command acked");
  a_ignored_stable: assert property (take && cmd.code inside {CMD_DRY_LIMIT,
    CMD_ADDR_GROUP, CMD_RANGE_SAVE, CMD_DISPLAY_TEST, CMD_KEYPAD_LOCK}
    |=> $stable({meas_run, auto_range, range_sel, load_mode})[*2])
    else $error("ignored command acted");
  a_load_never_two: assert property (load_mode != LOAD_MODE_TWO) else $error("mode two");
  a_load_complex: assert property (s_load(1'b1) |-> ##[0:1] load_mode == LOAD_MODE_THREE)
    else $error("complex load wrong");
  a_load_real: assert property (s_load(1'b0) |-> ##[0:1] load_mode == LOAD_MODE_ONE)
    else $error("real load wrong");
  a_start_runs: assert property (take && cmd.code == CMD_START |-> ##[1:2] meas_run)
    else $error("start ignored");
  a_stop_halts: assert property (take && cmd.code == CMD_STOP |-> ##[1:2] !meas_run)
    else $error("stop ignored");
  a_range_manual: assert property (take && cmd.code == CMD_RANGE_SET |-> ##[1:2] !auto_range)
    else $error("auto stays on");
endmodule
bind rcs_cmd_handler rcs_cmd_handler_asserts rcs_cmd_handler_asserts_inst (.clk_sys, .rstn,
  .ce, .cmd, .resp, .meas_run, .auto_range, .range_sel, .load_mode);
`default_nettype wire

// File: verif/rcs_host_model.sv
`default_nettype none
module rcs_host_model (
  // Clock
  input wire logic clk_sys,
  // Command and answer
  output rcs_pkg::rcs_cmd_type cmd,
  input wire rcs_pkg::rcs_resp_type resp
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcs_pkg::*;
  rcs_resp_type last;
  initial cmd = '0;
  // One command a call; idle argument is inverted so stale data never matches
  task automatic issue(input rcs_cmd_code_type c, input logic [15:0] a);
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, code: c, arg: a};
    @(posedge clk_sys);
    cmd <= '{valid: 1'b0, code: c, arg: ~a};
    #1 last = resp;
  endtask
endmodule
`default_nettype wire

// File: verif/test_legacy_command_status_handler.sv
`default_nettype none
module test_legacy_command_status_handler;
  timeunit 1ns;
  timeprecision 1ps;
  import rcs_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq, meas_run, auto_range;
  logic [3:0] range_sel;
  logic [1:0] load_mode;
  rcs_cmd_type cmd;
  rcs_resp_type resp;
  rcs_meas_type meas = '0;
  int fails = 0;
  int comparisons = 0;
  rcs_cmd_code_type naks[5] = '{CMD_MEAS_COMBINED, CMD_READ_COMBINED, CMD_DRY_LIMIT,
    CMD_ADDR_GROUP, CMD_ADDR_USER};
  rcs_cmd_code_type acks[3] = '{CMD_RANGE_SAVE, CMD_DISPLAY_TEST, CMD_KEYPAD_LOCK};

  rcs_cmd_handler rcs_cmd_handler_inst (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .cmd(cmd), .resp(resp), .meas(meas),
    .meas_run(meas_run), .auto_range(auto_range), .range_sel(range_sel),
    .load_mode(load_mode));
  rcs_host_model rcs_host_model_inst (.clk_sys(clk_sys), .cmd(cmd), .resp(resp));

  // Clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Command with expected answer kind; data left in the host model
  task automatic cm(input rcs_cmd_code_type c, input logic [15:0] a, input logic ack);
    rcs_host_model_inst.issue(c, a);
    chk({30'h0, rcs_host_model_inst.last.valid, rcs_host_model_inst.last.ack}, {30'h0, 1'b1, ack});
  endtask

  task automatic q(input rcs_cmd_code_type c, input logic [31:0] exp);
    cm(c, 16'h0, 1'b1);
    chk({8'h0, rcs_host_model_inst.last.data}, exp);
  endtask

  // Engine outputs packed as run, auto, range, load; one edge lets them land
  task automatic out(input logic [7:0] e);
    @(posedge clk_sys);
    #1 chk({24'h0, meas_run, auto_range, range_sel, load_mode}, {24'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // Engine result; value is scrambled once the strobe drops
  task automatic ms(input logic err, input logic [23:0] v);
    @(posedge clk_sys);
    meas <= '{valid: 1'b1, error: err, value: v};
    @(posedge clk_sys);
    meas <= '{valid: 1'b0, error: ~err, value: ~v};
  endtask

  // Hang guard
  initial begin
    #200us;
    fails++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    out(8'h41);
    wr(OFS_CTRL, 32'h3);
    rd(OFS_CTRL, 32'h3);
    foreach (acks[i]) cm(acks[i], 16'h1, 1'b1);
    foreach (naks[i]) cm(naks[i], 16'h1, 1'b0);
    out(8'h41);
    rd(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(8'h10, 32'h0);
    q(CMD_ESR_Q, 32'h20);
    q(CMD_ESR_Q, 32'h0);
    cm(CMD_ESE, 16'h20, 1'b1);
    q(CMD_ESE_Q, 32'h20);
    cm(CMD_DRY_LIMIT, 16'h0, 1'b0);
    cm(CMD_CLEAR_STATUS, 16'h0, 1'b1);
    q(CMD_ESR_Q, 32'h0);
    cm(CMD_LOAD_TYPE, 16'h1, 1'b1);
    out(8'h43);
    cm(CMD_LOAD_TYPE, 16'h0, 1'b1);
    out(8'h41);
    cm(CMD_RANGE_AUTO, 16'h0, 1'b1);
    out(8'h01);
    cm(CMD_RANGE_SET, 16'h5, 1'b1);
    out(8'h15);
    cm(CMD_START, 16'h0, 1'b1);
    out(8'h95);
    rd(OFS_STATE, 32'hAA);
    ms(1'b0, 24'h111111);
    ms(1'b0, 24'h222222);
    q(CMD_OPER_COND_Q, 32'h100);
    q(CMD_FETCH, 32'h222222);
    q(CMD_OPER_COND_Q, 32'h0);
    cm(CMD_FETCH, 16'h0, 1'b0);
    ms(1'b0, 24'h333333);
    q(CMD_OPER_COND_Q, 32'h100);
    cm(CMD_STOP, 16'h0, 1'b1);
    out(8'h15);
    ms(1'b1, 24'h0);
    rd(OFS_IRQ_STAT, 32'h7);
    q(CMD_QUES_COND_Q, 32'h200);
    q(CMD_QUES_EVENT_Q, 32'h200);
    q(CMD_QUES_EVENT_Q, 32'h0);
    q(CMD_QUES_COND_Q, 32'h200);
    q(CMD_OPER_EVENT_Q, 32'h100);
    cm(CMD_QUES_ENABLE, 16'h1234, 1'b1);
    q(CMD_QUES_ENABLE_Q, 32'h1234);
    cm(CMD_OPER_ENABLE, 16'h00FF, 1'b1);
    q(CMD_OPER_ENABLE_Q, 32'hFF);
    cm(CMD_STAT_PRESET, 16'h0, 1'b1);
    q(CMD_QUES_ENABLE_Q, {16'h0, ENABLE_PRESET});
    q(CMD_OPER_ENABLE_Q, {16'h0, ENABLE_PRESET});
    // Clock enable low: a write must not land
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd(OFS_CTRL, 32'h3);
    wr(OFS_CTRL, 32'h2);
    cm(CMD_RANGE_SAVE, 16'h0, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
